// ---- design/sld_regs.sv ----
// Behaviour
// - Writing 0 to the product-data flag starts an EEPROM read; flag 0 until done, then 1.
// - Writing 1 to the product-data flag starts an EEPROM write; flag 1 until done, then 0.
// - The EEPROM word address is the six-bit field at bits 23:18.
// - The eight-bit debounce field selects (value+1) ms and resets to zero.
// - The debounce field takes writes only while hot swap is enabled.
// - The product-data capability identifier reads 03h in the lowest byte.
// - The next-capability pointer reads F0h in bits 15:8.
// - The clock-recovery time counts fast training sets and resets to 54h.
// - Slot control holds six event enables, two indicator controls and a power bit, reset 0.
// - Lane retry count resets to 3h, TS1 count to 10h, low-power entry timer to 0400h.
// - Bits 0 to 4 of link config 0 are enables resetting to zero.
// - L0s exit latency resets to 2h and L1 exit latency to 19h, seven bits each.
// - Read bytes land in the low byte of the data register; EEPROM address is offset 40h.
`include "sld_map.svh"
module sld_regs #(
   parameter int MsCycles = `SLD_NS_PER_MS * `SLD_DEBOUNCE_UNIT_MS
                            / `SLD_CLK_PERIOD_NS
) (
   input wire logic clk,              // core clock, 25 MHz
   input wire logic rst,              // async reset, active high
   input wire logic cfgReq,           // config access, pulse
   input wire logic cfgWrite,         // 1 = write, 0 = read
   input wire logic [7:0] cfgAddr,    // byte address, dword aligned
   input wire logic [3:0] cfgBe,      // byte enables
   input wire logic [31:0] cfgWdata,  // write data
   output logic [31:0] cfgRdata,      // read data
   output logic cfgAck,               // access done, pulse
   input wire logic hotSwapPin,       // hot swap enable strap/pin
   input wire logic [6:0] slotEvents, // slot status bits 22:16
   output logic [15:0] slotCtrl,      // slot control word
   output logic [4:0] linkEnables,    // link training enables
   output logic [2:0] laneRetry,      // lane negotiation retries
   output logic [4:0] ts1Count,       // TS1 ordered-set count
   output logic [15:0] l1EntryTimer,  // low-power entry timer
   output logic [9:0] l0sLifetime,    // L0s lifetime timer
   output logic [15:0] l1Lifetime,    // L1 lifetime timer
   output logic [7:0] cdrTime,        // clock recovery, in FTS sets
   output logic [6:0] l0sExitLat,     // L0s to L0 exit latency
   output logic [6:0] l1ExitLat,      // L1 to L0 exit latency
   output logic debounceTick,         // end of debounce interval
   output logic eepReq,               // EEPROM cycle request
   output logic eepWrite,             // EEPROM cycle is a write
   output logic [7:0] eepAddr,        // EEPROM byte address
   input wire logic eepDone,          // EEPROM cycle finished
   input wire logic [7:0] eepRdData,  // EEPROM read byte
   output logic [7:0] vpdRdByte,      // byte for data register
   output logic vpdRdValid            // vpdRdByte updated
);
   // ------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------
   localparam logic [14:0] MsLast = 15'(MsCycles - 1);

   logic wrStb;
   logic rdStb;
   logic hotSwapEn;
   logic [10:0] slotCtrl_q;
   logic [4:0] linkEn_q;
   logic [2:0] laneRetry_q;
   logic [4:0] ts1Count_q;
   logic [15:0] l1Entry_q;
   logic [9:0] l0sLife_q;
   logic [15:0] l1Life_q;
   logic [7:0] cdr_q;
   logic [6:0] l0sExit_q;
   logic [6:0] l1Exit_q;
   logic [7:0] debounce_q;
   logic [5:0] vpdAddr_q;
   logic [31:0] rdMux;
   logic [14:0] msCnt_q;
   logic [7:0] msElapsed_q;

   sld_vpd_if vpd ();

   assign wrStb = cfgReq & cfgWrite;
   assign rdStb = cfgReq & ~cfgWrite;

   // ------------------------------------------------------------
   // Hot swap enable from its pin
   // ------------------------------------------------------------
   sld_sync3 u_hsSync (
      .clk(clk),
      .rst(rst),
      .asyncIn(hotSwapPin),
      .syncOut(hotSwapEn)
   );

   // ------------------------------------------------------------
   // Slot control
   // ------------------------------------------------------------
   // slot control fields
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         slotCtrl_q <= 11'h000;
      end else if (wrStb && cfgAddr[7:2] == `SLD_OFF_SLOT >> 2) begin
         if (cfgBe[0]) begin
            slotCtrl_q[7:0] <= cfgWdata[7:0];
         end
         if (cfgBe[1]) begin
            slotCtrl_q[10:8] <= cfgWdata[10:8];
         end
      end
   end

   assign slotCtrl = {5'h00, slotCtrl_q};

   // ------------------------------------------------------------
   // Link training configuration 0
   // ------------------------------------------------------------
   // enables in bits 0 to 4
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         linkEn_q <= 5'h00;
         laneRetry_q <= `SLD_RST_LANE_RETRY;
         ts1Count_q <= `SLD_RST_TS1_COUNT;
         l1Entry_q <= `SLD_RST_L1_ENTRY;
      end else if (wrStb && cfgAddr[7:2] == `SLD_OFF_LTC0 >> 2) begin
         if (cfgBe[0]) begin
            linkEn_q <= cfgWdata[4:0];
            laneRetry_q <= cfgWdata[7:5];
         end
         if (cfgBe[1]) begin
            ts1Count_q <= cfgWdata[12:8];
         end
         if (cfgBe[2]) begin
            l1Entry_q[7:0] <= cfgWdata[23:16];
         end
         if (cfgBe[3]) begin
            l1Entry_q[15:8] <= cfgWdata[31:24];
         end
      end
   end

   // ------------------------------------------------------------
   // Link training configuration 1
   // ------------------------------------------------------------
   // Lifetime timers for the low-power states
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         l0sLife_q <= 10'h000;
         l1Life_q <= 16'h0000;
      end else if (wrStb && cfgAddr[7:2] == `SLD_OFF_LTC1 >> 2) begin
         if (cfgBe[0]) begin
            l0sLife_q[7:0] <= cfgWdata[7:0];
         end
         if (cfgBe[1]) begin
            l0sLife_q[9:8] <= cfgWdata[9:8];
         end
         if (cfgBe[2]) begin
            l1Life_q[7:0] <= cfgWdata[23:16];
         end
         if (cfgBe[3]) begin
            l1Life_q[15:8] <= cfgWdata[31:24];
         end
      end
   end

   // ------------------------------------------------------------
   // Link training configuration 2
   // ------------------------------------------------------------
   // clock recovery time
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cdr_q <= `SLD_RST_CDR_TIME;
         l0sExit_q <= `SLD_RST_L0S_EXIT;
         l1Exit_q <= `SLD_RST_L1_EXIT;
      end else if (wrStb && cfgAddr[7:2] == `SLD_OFF_LTC2 >> 2) begin
         if (cfgBe[0]) begin
            cdr_q <= cfgWdata[7:0];
         end
         if (cfgBe[1]) begin
            l0sExit_q <= cfgWdata[14:8];
         end
         if (cfgBe[2]) begin
            l1Exit_q <= cfgWdata[22:16];
         end
      end
   end

   // ------------------------------------------------------------
   // Hot swap debounce setting
   // ------------------------------------------------------------
   // writable only with hot swap on
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         debounce_q <= `SLD_RST_DEBOUNCE;
      end else if (wrStb && cfgAddr[7:2] == `SLD_OFF_LTC2 >> 2
                   && cfgBe[3] && hotSwapEn) begin
         debounce_q <= cfgWdata[31:24];
      end
   end

   // Millisecond prescaler; free running so intervals stay aligned
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         msCnt_q <= 15'h0000;
      end else if (msCnt_q == MsLast) begin
         msCnt_q <= 15'h0000;
      end else begin
         msCnt_q <= msCnt_q + 15'h0001;
      end
   end

   // interval of value plus one ms
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         msElapsed_q <= 8'h00;
         debounceTick <= 1'b0;
      end else begin
         debounceTick <= 1'b0;
         if (msCnt_q == MsLast) begin
            if (msElapsed_q >= debounce_q) begin
               msElapsed_q <= 8'h00;
               debounceTick <= 1'b1;
            end else begin
               msElapsed_q <= msElapsed_q + 8'h01;
            end
         end
      end
   end

   // ------------------------------------------------------------
   // Product-data capability
   // ------------------------------------------------------------
   // six-bit word address at 23:18; frozen while a cycle runs
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         vpdAddr_q <= 6'h00;
      end else if (wrStb && cfgAddr[7:2] == `SLD_OFF_VPD >> 2
                   && cfgBe[2] && !vpd.busy) begin
         vpdAddr_q <= cfgWdata[23:`SLD_VPD_ADDR_LSB];
      end
   end

   // write of the flag starts a cycle
   // a start while busy is dropped
   assign vpd.start = wrStb && cfgAddr[7:2] == `SLD_OFF_VPD >> 2
                      && cfgBe[3] && !vpd.busy;
   assign vpd.opWrite = cfgWdata[`SLD_VPD_FLAG_BIT];
   // A fresh address in the same write wins over the stored one
   assign vpd.wordAddr = cfgBe[2] ? cfgWdata[23:`SLD_VPD_ADDR_LSB]
                                  : vpdAddr_q;

   sld_vpd_seq u_seq (
      .clk(clk),
      .rst(rst),
      .vpd(vpd),
      .eepReq(eepReq),
      .eepWrite(eepWrite),
      .eepAddr(eepAddr),
      .eepDone(eepDone),
      .eepRdData(eepRdData),
      .rdByte(vpdRdByte),
      .rdValid(vpdRdValid)
   );

   // ------------------------------------------------------------
   // Read path
   // ------------------------------------------------------------
   // reserved and unmapped read zero
   always_comb begin
      rdMux = 32'h0000_0000;
      unique case (cfgAddr[7:2])
         `SLD_OFF_SLOT >> 2: rdMux = {9'h000, slotEvents, 5'h00,
                                      slotCtrl_q};
         `SLD_OFF_LTC0 >> 2: rdMux = {l1Entry_q, 3'h0, ts1Count_q,
                                      laneRetry_q, linkEn_q};
         `SLD_OFF_LTC1 >> 2: rdMux = {l1Life_q, 6'h00, l0sLife_q};
         `SLD_OFF_LTC2 >> 2: rdMux = {debounce_q, 1'b0, l1Exit_q,
                                      1'b0, l0sExit_q, cdr_q};
         `SLD_OFF_VPD >> 2: rdMux = {vpd.flag, 7'h00, vpdAddr_q, 2'h0,
                                     `SLD_VPD_NEXT_PTR, `SLD_VPD_CAP_ID};
         default: rdMux = 32'h0000_0000;
      endcase
   end

   // Answer every access one cycle later; unmapped writes are dropped
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cfgRdata <= 32'h0000_0000;
         cfgAck <= 1'b0;
      end else begin
         cfgAck <= cfgReq;
         if (rdStb) begin
            cfgRdata <= rdMux;
         end
      end
   end

   // ------------------------------------------------------------
   // Outputs to the link and slot logic
   // ------------------------------------------------------------
   assign linkEnables = linkEn_q;
   assign laneRetry = laneRetry_q;
   assign ts1Count = ts1Count_q;
   assign l1EntryTimer = l1Entry_q;
   assign l0sLifetime = l0sLife_q;
   assign l1Lifetime = l1Life_q;
   assign cdrTime = cdr_q;
   assign l0sExitLat = l0sExit_q;
   assign l1ExitLat = l1Exit_q;
endmodule : sld_regs

// ---- design/sld_map.svh ----
`ifndef SLD_MAP_SVH
`define SLD_MAP_SVH
// ------------------------------------------------------------
// Register offsets (byte addresses in configuration space)
// ------------------------------------------------------------
`define SLD_OFF_SLOT 8'h00_C8
`define SLD_OFF_LTC0 8'h00_CC
`define SLD_OFF_LTC1 8'h00_D0
`define SLD_OFF_LTC2 8'h00_D4
`define SLD_OFF_VPD 8'h00_D8
// ------------------------------------------------------------
// Field positions and constant values
// ------------------------------------------------------------
`define SLD_VPD_CAP_ID 8'h00_03
`define SLD_VPD_NEXT_PTR 8'h00_F0
`define SLD_VPD_ADDR_LSB 18
`define SLD_VPD_FLAG_BIT 31
`define SLD_VPD_EEP_BASE 8'h00_40
// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define SLD_RST_LANE_RETRY 3'h3
`define SLD_RST_TS1_COUNT 5'h1_0
`define SLD_RST_L1_ENTRY 16'h0400
`define SLD_RST_CDR_TIME 8'h00_54
`define SLD_RST_L0S_EXIT 7'h0_02
`define SLD_RST_L1_EXIT 7'h0_19
`define SLD_RST_DEBOUNCE 8'h00_00
// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define SLD_CLK_PERIOD_NS 40
`define SLD_DEBOUNCE_UNIT_MS 1
`define SLD_NS_PER_MS 1000000
`endif

// ---- design/sld_pkg.sv ----
package sld_pkg;
   // Product-data cycle engine states
   typedef enum logic [0:0] {
      SLD_IDLE = 1'b0,
      SLD_BUSY = 1'b1
   } sld_vpd_state_t;
endpackage : sld_pkg

// ---- design/sld_vpd_if.sv ----
// Request and status between register bank and cycle engine
interface sld_vpd_if;
   logic start;
   logic opWrite;
   logic [5:0] wordAddr;
   logic flag;
   logic busy;
   modport regs (output start, output opWrite, output wordAddr,
                 input flag, input busy);
   modport seq (input start, input opWrite, input wordAddr,
                output flag, output busy);
endinterface : sld_vpd_if

// ---- design/sld_sync3.sv ----
module sld_sync3 (
   input wire logic clk,       // core clock
   input wire logic rst,       // async reset, active high
   input wire logic asyncIn,   // level from a pin
   output logic syncOut        // filtered level
);
   logic s1_q;
   logic s2_q;
   logic s3_q;

   // Three-stage chain; only stages two and three are compared
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
         s3_q <= 1'b0;
      end else begin
         s1_q <= asyncIn;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   // Accept a new level once two stages agree, rejecting a single glitch
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         syncOut <= 1'b0;
      end else if (s2_q == s3_q) begin
         syncOut <= s3_q;
      end
   end
endmodule : sld_sync3

// ---- design/sld_vpd_seq.sv ----
`include "sld_map.svh"
module sld_vpd_seq (
   input wire logic clk,            // core clock
   input wire logic rst,            // async reset, active high
   sld_vpd_if.seq vpd,              // request from register bank
   output logic eepReq,             // EEPROM cycle request, level
   output logic eepWrite,           // 1 = write cycle
   output logic [7:0] eepAddr,      // EEPROM byte address
   input wire logic eepDone,        // cycle finished, pulse
   input wire logic [7:0] eepRdData, // byte returned by a read
   output logic [7:0] rdByte,       // byte for the data register
   output logic rdValid             // rdByte updated, pulse
);
   sld_pkg::sld_vpd_state_t state_q;
   logic flag_q;

   assign vpd.flag = flag_q;
   assign vpd.busy = (state_q == sld_pkg::SLD_BUSY);
   assign eepReq = (state_q == sld_pkg::SLD_BUSY);

   // Cycle state; a start while busy is dropped, software must poll
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_q <= sld_pkg::SLD_IDLE;
      end else begin
         unique case (state_q)
            sld_pkg::SLD_IDLE: begin
               if (vpd.start) begin
                  state_q <= sld_pkg::SLD_BUSY;
               end
            end
            sld_pkg::SLD_BUSY: begin
               if (eepDone) begin
                  state_q <= sld_pkg::SLD_IDLE;
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         flag_q <= 1'b0;
      end else if (state_q == sld_pkg::SLD_IDLE && vpd.start) begin
         flag_q <= vpd.opWrite;
      end else if (state_q == sld_pkg::SLD_BUSY && eepDone) begin
         flag_q <= ~flag_q;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         eepAddr <= 8'h00_00;
         eepWrite <= 1'b0;
      end else if (state_q == sld_pkg::SLD_IDLE && vpd.start) begin
         eepAddr <= 8'({2'b00, vpd.wordAddr} + `SLD_VPD_EEP_BASE);
         eepWrite <= vpd.opWrite;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rdByte <= 8'h00_00;
         rdValid <= 1'b0;
      end else begin
         rdValid <= 1'b0;
         if (state_q == sld_pkg::SLD_BUSY && eepDone && !eepWrite) begin
            rdByte <= eepRdData;
            rdValid <= 1'b1;
         end
      end
   end
endmodule : sld_vpd_seq

// ---- bench/sld_regs_assertions.sv ----
`include "sld_map.svh"
module sld_regs_checker (
   input wire logic clk,             // core clock
   input wire logic rst,             // async reset
   input wire logic cfgReq,          // access request
   input wire logic cfgWrite,        // access is a write
   input wire logic [7:0] cfgAddr,   // byte address
   input wire logic [3:0] cfgBe,     // byte enables
   input wire logic [31:0] cfgWdata, // write data
   input wire logic [31:0] cfgRdata, // read data
   input wire logic cfgAck,          // access done
   input wire logic [15:0] slotCtrl, // slot control word
   input wire logic eepReq,          // EEPROM cycle open
   input wire logic eepWrite,        // EEPROM cycle is a write
   input wire logic [7:0] eepAddr,   // EEPROM byte address
   input wire logic eepDone,         // EEPROM cycle end
   input wire logic [7:0] eepRdData, // EEPROM read byte
   input wire logic [7:0] vpdRdByte, // returned byte
   input wire logic vpdRdValid       // returned byte strobe
);
   timeunit 1ns;
   timeprecision 1ns;
   // ----------------------------------------
   // Properties
   // ----------------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   logic vpdGo;
   // Start of an EEPROM cycle; starts while busy are dropped
   assign vpdGo = cfgReq && cfgWrite && cfgBe[3] && !eepReq &&
                  ({cfgAddr[7:2], 2'b00} == `SLD_OFF_VPD);
   a_ack_follows: assert property (cfgReq |=> cfgAck)
      else $error("no acknowledge after request");
   a_ack_cause: assert property (cfgAck |-> $past(cfgReq))
      else $error("acknowledge without request");
   a_read_start: assert property (
      vpdGo && !cfgWdata[31] |=> eepReq && !eepWrite)
      else $error("read cycle not started");
   a_write_start: assert property (
      vpdGo && cfgWdata[31] |=> eepReq && eepWrite)
      else $error("write cycle not started");
   a_addr_taken: assert property (
      vpdGo && cfgBe[2] |=>
      eepAddr == {2'b00, $past(cfgWdata[23:18])} + 8'h40)
      else $error("wrong EEPROM address");
   a_req_stands: assert property (eepReq && !eepDone |=> eepReq)
      else $error("cycle dropped before done");
   a_req_ends: assert property (eepReq && eepDone |=> !eepReq)
      else $error("cycle kept open after done");
   a_byte_return: assert property (
      eepReq && eepDone && !eepWrite |=>
      vpdRdValid && vpdRdByte == $past(eepRdData))
      else $error("read byte not returned");
   a_valid_cause: assert property (vpdRdValid |-> $past(eepDone))
      else $error("byte strobe without done");
   a_cap_fixed: assert property (
      cfgReq && !cfgWrite && {cfgAddr[7:2], 2'b00} == `SLD_OFF_VPD
      |=> cfgRdata[15:0] == 16'hF003)
      else $error("capability header wrong");
   a_slot_rsvd: assert property (
      cfgReq && !cfgWrite && {cfgAddr[7:2], 2'b00} == `SLD_OFF_SLOT
      |=> cfgRdata[15:11] == 5'h00 && cfgRdata[31:23] == 9'h000
      && slotCtrl[15:11] == 5'h00)
      else $error("slot reserved bits set");
   c_read: cover property (vpdGo && !cfgWdata[31]);
   c_write: cover property (vpdGo && cfgWdata[31]);
   c_byte: cover property (vpdRdValid);
endmodule : sld_regs_checker

bind sld_regs sld_regs_checker u_chk (.clk(clk), .rst(rst),
   .cfgReq(cfgReq), .cfgWrite(cfgWrite), .cfgAddr(cfgAddr),
   .cfgBe(cfgBe), .cfgWdata(cfgWdata), .cfgRdata(cfgRdata),
   .cfgAck(cfgAck), .slotCtrl(slotCtrl), .eepReq(eepReq),
   .eepWrite(eepWrite), .eepAddr(eepAddr), .eepDone(eepDone),
   .eepRdData(eepRdData), .vpdRdByte(vpdRdByte),
   .vpdRdValid(vpdRdValid));

// ---- bench/sld_eep_model.sv ----
module sld_eep_model (
   input wire logic clk,            // core clock
   input wire logic rst,            // async reset
   input wire logic eepReq,         // cycle open
   input wire logic [7:0] eepAddr,  // byte address
   input wire logic [3:0] waitCyc,  // answer delay in cycles
   output logic eepDone,            // cycle end pulse
   output logic [7:0] eepRdData     // read byte
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [3:0] cntQ;
   logic answer;
   // ----------------------------------------
   // Delayed answer
   // ----------------------------------------
   assign answer = eepReq && !eepDone && (cntQ == waitCyc);
   // Count open cycles; a slow delay keeps the flag busy for a while
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cntQ <= 4'h0;
         eepDone <= 1'b0;
      end else begin
         cntQ <= (eepReq && !answer && !eepDone) ? cntQ + 4'h1 : 4'h0;
         eepDone <= answer;
      end
   end
   // Data only valid with done; toggles otherwise so stale bytes show
   always_ff @(posedge clk or posedge rst) begin
      if (rst) eepRdData <= 8'h00;
      else if (answer) eepRdData <= eepAddr ^ 8'hA5;
      else eepRdData <= ~eepRdData;
   end
endmodule : sld_eep_model

// ---- bench/tb_top.sv ----
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int MsC = 4;
   logic clk = 1'b0, rst = 1'b1, cfgReq = 1'b0, cfgWrite = 1'b0;
   logic hotSwapPin = 1'b0, cfgAck, eepReq, eepWrite, eepDone;
   logic debounceTick, vpdRdValid;
   logic [7:0] cfgAddr = 8'h00, eepAddr, eepRdData, vpdRdByte;
   logic [3:0] cfgBe = 4'h0, waitCyc = 4'h0;
   logic [31:0] cfgWdata = 32'h0, cfgRdata, q;
   logic [15:0] slotCtrl;
   logic [6:0] slotEvents = 7'h55;
   logic [15:0] l1EntryTimer, l1Lifetime;
   logic [9:0] l0sLifetime;
   logic [7:0] cdrTime;
   logic [6:0] l0sExitLat, l1ExitLat;
   logic [4:0] linkEnables, ts1Count;
   logic [2:0] laneRetry;
   int num_errors = 0, compares = 0, n;
   logic [7:0] addrs [5] = '{8'hC8, 8'hCC, 8'hD0, 8'hD4, 8'hE0};
   logic [31:0] exps [5] = '{32'h0055_07FF, 32'hFFFF_1FFF,
      32'hFFFF_03FF, 32'h007F_7FFF, 32'h0000_0000};

   always #20 clk = ~clk;

   sld_regs #(.MsCycles(MsC)) dut (.clk(clk), .rst(rst), .cfgReq(cfgReq),
      .cfgWrite(cfgWrite), .cfgAddr(cfgAddr), .cfgBe(cfgBe),
      .cfgWdata(cfgWdata), .cfgRdata(cfgRdata), .cfgAck(cfgAck),
      .hotSwapPin(hotSwapPin), .slotEvents(slotEvents),
      .slotCtrl(slotCtrl), .linkEnables(linkEnables),
      .laneRetry(laneRetry), .ts1Count(ts1Count),
      .l1EntryTimer(l1EntryTimer), .l0sLifetime(l0sLifetime),
      .l1Lifetime(l1Lifetime), .cdrTime(cdrTime),
      .l0sExitLat(l0sExitLat), .l1ExitLat(l1ExitLat),
      .debounceTick(debounceTick),
      .eepReq(eepReq), .eepWrite(eepWrite), .eepAddr(eepAddr),
      .eepDone(eepDone), .eepRdData(eepRdData), .vpdRdByte(vpdRdByte),
      .vpdRdValid(vpdRdValid));
   sld_eep_model eep (.clk(clk), .rst(rst), .eepReq(eepReq),
      .eepAddr(eepAddr), .waitCyc(waitCyc), .eepDone(eepDone),
      .eepRdData(eepRdData));

   // ----------------------------------------
   // Access and compare tasks
   // ----------------------------------------
   task automatic chk(input string nm, input logic [31:0] e,
         input logic [31:0] g);
      compares++;
      if (g !== e) begin
         $display("wrong value %s expected %h seen %h", nm, e, g);
         num_errors++;
      end
   endtask : chk

   // Request set up at a falling edge, answer taken at the next falling edge
   task automatic cfg(input logic w, input logic [7:0] a,
         input logic [3:0] be, input logic [31:0] d);
      @(negedge clk);
      cfgReq = 1'b1;
      cfgWrite = w;
      cfgAddr = a;
      cfgBe = be;
      cfgWdata = d;
      @(negedge clk);
      cfgReq = 1'b0;
      q = cfgRdata;
      chk("cfgAck", 32'h1, {31'h0, cfgAck});
   endtask : cfg

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      cfg(1'b0, a, 4'hF, 32'h0);
      chk("cfgRdata", e, q);
   endtask : rd

   // Field outputs toward the link logic, laid out as their registers
   task automatic outs(input logic [31:0] e0, input logic [31:0] e1,
         input logic [31:0] e2);
      chk("ltc0Pins", e0, {l1EntryTimer, 3'h0, ts1Count, laneRetry,
         linkEnables});
      chk("ltc1Pins", e1, {l1Lifetime, 6'h00, l0sLifetime});
      chk("ltc2Pins", e2, {8'h00, 1'b0, l1ExitLat, 1'b0, l0sExitLat,
         cdrTime});
   endtask : outs

   // Software waits for the completion value before going on
   task automatic poll(input logic f);
      n = 0;
      q = {~f, 31'h0};
      while (q[31] !== f && n < 40) begin
         cfg(1'b0, 8'hD8, 4'hF, 32'h0);
         n++;
      end
      chk("flagDone", {31'h0, f}, {31'h0, q[31]});
   endtask : poll

   task automatic close_out;
      $display("errors %0d compares %0d", num_errors, compares);
      if (num_errors == 0 && compares > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : close_out

   // ----------------------------------------
   // Tests
   // ----------------------------------------
   initial begin
      repeat (4) @(negedge clk);
      rst = 1'b0;
      rd(8'hC8, 32'h0055_0000);
      rd(8'hCC, 32'h0400_1060);
      rd(8'hD0, 32'h0000_0000);
      rd(8'hD4, 32'h0019_0254);
      rd(8'hD8, 32'h0000_F003);
      outs(32'h0400_1060, 32'h0000_0000, 32'h0019_0254);
      // All ones to every register but the product-data one; hot swap still off so debounce holds
      foreach (addrs[i]) begin
         cfg(1'b1, addrs[i], 4'hF, 32'hFFFF_FFFF);
         rd(addrs[i], exps[i]);
      end
      chk("slotCtrl", 32'h07FF, {16'h0, slotCtrl});
      outs(32'hFFFF_1FFF, 32'hFFFF_03FF, 32'h007F_7FFF);
      hotSwapPin = 1'b1;
      repeat (6) @(negedge clk);
      cfg(1'b1, 8'hD4, 4'h8, 32'h0200_0000);
      rd(8'hD4, 32'h027F_7FFF);
      // Interval between two ticks is (value + 1) ms
      for (int k = 0; k < 2; k++) begin
         n = 0;
         while (debounceTick !== 1'b1 && n < 100) begin
            @(negedge clk);
            n++;
         end
         @(negedge clk);
      end
      n = 1;
      while (debounceTick !== 1'b1 && n < 100) begin
         @(negedge clk);
         n++;
      end
      chk("tickGap", 3 * MsC, n);
      // Read cycle, prompt answer
      cfg(1'b1, 8'hD8, 4'hC, 32'h00A8_0000);
      chk("eepAddr", 32'h6A, {24'h0, eepAddr});
      poll(1'b1);
      chk("rdByte", 32'h6A ^ 32'hA5, {24'h0, vpdRdByte});
      rd(8'hD8, 32'h80A8_F003);
      // Write cycle at top address, slow answer, restart refused
      waitCyc = 4'd9;
      cfg(1'b1, 8'hD8, 4'hF, 32'h80FC_1234);
      chk("eepWrite", 32'h1, {31'h0, eepWrite});
      chk("eepAddr", 32'h7F, {24'h0, eepAddr});
      rd(8'hD8, 32'h80FC_F003);
      cfg(1'b1, 8'hD8, 4'hC, 32'h0004_0000);
      poll(1'b0);
      rd(8'hD8, 32'h00FC_F003);
      close_out();
   end

   // Tests take under two hundred cycles; give ample margin
   initial begin
      #100000;
      num_errors++;
      close_out();
   end
endmodule : tb_top
